// ---- core/ilwc_core.v ----
// interrupt control, latency, wake and context save/restore unit
`timescale 1ns/1ps
`include "ilwc_regs.vh"
module ilwc_core (
  input wire clock_in,
  input wire nrst_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire cyc_end_in,
  input wire q4_in,
  input wire ext_pin_in,
  input wire timer0_ovf_in,
  input wire pin_change_in,
  input wire periph_irq_in,
  input wire sleeping_in,
  input wire wake_event_in,
  input wire ret_isr_in,
  input wire [`ILWC_PC_W-1:0] pc_in,
  input wire [63:0] ctx_in,
  input wire bank31_we_in,
  input wire [2:0] bank31_idx_in,
  input wire [7:0] bank31_data_in,
  output reg [7:0] bank31_rdata_out,
  output reg flush_out,
  output reg push_out,
  output reg [`ILWC_PC_W-1:0] push_pc_out,
  output reg vector_load_out,
  output reg [`ILWC_PC_W-1:0] vector_out,
  output reg pop_out,
  output reg restore_out,
  output reg [63:0] restore_ctx_out,
  output reg wake_out,
  output reg irq_out
);
  localparam ST_RUN = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_POST = 2'b10;
  localparam ST_ISR = 2'b11;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] ictrl_r;
  reg edge_sel_r;
  reg [4:0] evstat_r;
  reg [4:0] evmask_r;
  reg [1:0] lat_cnt_r;
  reg ext_pend_r;
  reg pin_change_r;
  wire ext_edge;
  wire [7:0] sh_rdata;
  wire [63:0] sh_ctx;
  wire [63:0] ctx_masked;
  wire sh_sw_we;
  wire [2:0] sh_sw_idx;
  wire [2:0] sh_rd_idx;
  wire req;
  wire take;
  wire do_exit;
  wire [4:0] ev_set;
  reg [7:0] ictrl_nxt;
  reg [4:0] evstat_nxt;
  reg [1:0] lat_cnt_nxt;
  reg ext_pend_nxt;
  wire wr_ictrl;
  wire wr_edge;
  wire wr_evstat;
  wire wr_evmask;
  wire in_wait;
  wire in_isr;
  wire ext_flag_set;
  wire asleep_wake;

  // a source asks only while both its flag and its enable are set
  function pair_on;
    input en;
    input fl;
    begin
      pair_on = en & fl;
    end
  endfunction

  function [2:0] sh_index;
    input [3:0] a;
    begin
      sh_index = a[2:0] - 3'h4;
    end
  endfunction

  function is_shadow;
    input [3:0] a;
    begin
      is_shadow = (a >= `ILWC_OFS_SH_W) && (a <= `ILWC_OFS_SH_PC_HIGH_LATCH);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  ilwc_edge_det u_edge (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .pin_in(ext_pin_in),
    .rising_sel_in(edge_sel_r),
    .edge_out(ext_edge)
  );

  // timeout and powerdown bits never enter the context saved on entry
  assign ctx_masked = {ctx_in[63:16], ctx_in[15:8] & `ILWC_STATUS_SAVE_MASK, ctx_in[7:0]};

  // core bank-31 writes share the array with the register port
  assign sh_sw_we = bank31_we_in | (wr_in & is_shadow(addr_in));
  assign sh_sw_idx = bank31_we_in ? bank31_idx_in : sh_index(addr_in);
  // only a port read of a shadow address borrows the read index from the core
  assign sh_rd_idx = (rd_in && is_shadow(addr_in)) ? sh_index(addr_in) : bank31_idx_in;

  // a save beats a software write in the same cycle so the entry context is never torn
  ilwc_shadow u_shadow (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .save_in(take),
    .ctx_in(ctx_masked),
    .sw_we_in(sh_sw_we),
    .sw_idx_in(sh_sw_idx),
    .sw_data_in(bank31_we_in ? bank31_data_in : wdata_in),
    .rd_idx_in(sh_rd_idx),
    .rd_data_out(sh_rdata),
    .ctx_out(sh_ctx)
  );

  //////////////////////////////////////////////////////////////////////////////
  // request: enabled flag pairs, peripherals behind their group enable
  assign req = pair_on(ictrl_r[`ILWC_B_T0IE], ictrl_r[`ILWC_B_T0IF]) |
               pair_on(ictrl_r[`ILWC_B_EXTE], ictrl_r[`ILWC_B_EXTF]) |
               pair_on(ictrl_r[`ILWC_B_IOCE], ictrl_r[`ILWC_B_IOCF]) |
               pair_on(ictrl_r[`ILWC_B_PERIPHERAL_IRQ_ENABLE], periph_irq_in);
  // vector taken at a cycle boundary once latency has run out
  // register port write decodes
  assign wr_ictrl = wr_in && (addr_in == `ILWC_OFS_ICTRL);
  assign wr_edge = wr_in && (addr_in == `ILWC_OFS_EDGE);
  assign wr_evstat = wr_in && (addr_in == `ILWC_OFS_EVSTAT);
  assign wr_evmask = wr_in && (addr_in == `ILWC_OFS_EVMASK);
  assign in_wait = (state_r == ST_WAIT);
  assign in_isr = (state_r == ST_ISR);
  // pin flag only lands inside the Q4-Q1 window
  assign ext_flag_set = ext_pend_r && q4_in;
  assign asleep_wake = sleeping_in && wake_event_in;
  assign take = in_wait && cyc_end_in && (lat_cnt_r == 2'h0);
  assign do_exit = in_isr && ret_isr_in;
  assign ev_set = {ext_edge, ext_flag_set, asleep_wake, do_exit, take};

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        // a sleeping core cannot vector; the wake path decides after one instruction
        if (asleep_wake) begin
          state_nxt = ST_POST;
        end else if (req && ictrl_r[`ILWC_B_GIE] && !sleeping_in) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_POST: begin
        // one instruction after sleep completes first
        if (cyc_end_in) begin
          state_nxt = (ictrl_r[`ILWC_B_GIE] && req) ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (take) begin
          state_nxt = ST_ISR;
        end
      end
      ST_ISR: begin
        if (ret_isr_in) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // latency counter: reloaded outside the wait state, counts cycle ends inside it
  always @* begin
    lat_cnt_nxt = lat_cnt_r;
    if (!in_wait) begin
      lat_cnt_nxt = `ILWC_LAT_LOAD;
    end else if (cyc_end_in && (lat_cnt_r != 2'h0)) begin
      lat_cnt_nxt = lat_cnt_r - 2'h1;
    end
  end

  // async pin edge waits for the Q4 window before flagging
  always @* begin
    ext_pend_nxt = ext_pend_r;
    if (ext_edge) begin
      ext_pend_nxt = 1'b1;
    end else if (q4_in) begin
      ext_pend_nxt = 1'b0;
    end
  end

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= ST_RUN;
      lat_cnt_r <= 2'h0;
      ext_pend_r <= 1'b0;
      pin_change_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      lat_cnt_r <= lat_cnt_nxt;
      ext_pend_r <= ext_pend_nxt;
      pin_change_r <= pin_change_in;
    end
  end

  // interrupt control next value: hardware set beats software clear
  always @* begin
    ictrl_nxt = ictrl_r;
    if (wr_ictrl) begin
      // the write mask leaves the read-only change summary alone
      ictrl_nxt = (ictrl_r & ~`ILWC_ICTRL_WMASK) | (wdata_in & `ILWC_ICTRL_WMASK);
    end
    if (timer0_ovf_in) begin
      ictrl_nxt[`ILWC_B_T0IF] = 1'b1;
    end
    if (ext_flag_set) begin
      ictrl_nxt[`ILWC_B_EXTF] = 1'b1;
    end
    // change summary is read-only and follows the pin-change sources
    ictrl_nxt[`ILWC_B_IOCF] = pin_change_r;
    if (take) begin
      ictrl_nxt[`ILWC_B_GIE] = 1'b0;
    end else if (do_exit) begin
      ictrl_nxt[`ILWC_B_GIE] = 1'b1;
    end
  end

  // event status: a new event beats a write-one clear in the same cycle
  always @* begin
    evstat_nxt = evstat_r | ev_set;
    if (wr_evstat) begin
      evstat_nxt = (evstat_r & ~wdata_in[4:0]) | ev_set;
    end
  end

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ictrl_r <= `ILWC_ICTRL_RST;
      edge_sel_r <= 1'b0;
      evmask_r <= `ILWC_EVMASK_RST;
      evstat_r <= 5'h00;
    end else begin
      ictrl_r <= ictrl_nxt;
      evstat_r <= evstat_nxt;
      if (wr_edge) begin
        edge_sel_r <= wdata_in[0];
      end
      if (wr_evmask) begin
        evmask_r <= wdata_in[4:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer strobes, one cycle each; wake_out and irq_out are levels that follow their sources
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flush_out <= 1'b0;
      push_out <= 1'b0;
      push_pc_out <= {`ILWC_PC_W{1'b0}};
      vector_load_out <= 1'b0;
      vector_out <= `ILWC_VECTOR;
      pop_out <= 1'b0;
      restore_out <= 1'b0;
      restore_ctx_out <= 64'h0;
      wake_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      flush_out <= take;
      push_out <= take;
      push_pc_out <= pc_in;
      vector_load_out <= take;
      vector_out <= `ILWC_VECTOR;
      pop_out <= do_exit;
      restore_out <= do_exit;
      // shadow contents win over any direct edits made in the routine
      restore_ctx_out <= sh_ctx;
      wake_out <= asleep_wake;
      // current events are folded in so the line rises without an extra cycle
      irq_out <= |((evstat_r | ev_set) & evmask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
      bank31_rdata_out <= 8'h00;
    end else begin
      // register port read data is zero outside its slot so an idle port never shows stale contents; bank-31 read data always follows the array
      bank31_rdata_out <= sh_rdata;
      if (!rd_in) begin
        rdata_out <= 8'h00;
      end else if (addr_in == `ILWC_OFS_ICTRL) begin
        rdata_out <= ictrl_r;
      end else if (addr_in == `ILWC_OFS_EDGE) begin
        rdata_out <= {7'h00, edge_sel_r};
      end else if (addr_in == `ILWC_OFS_EVSTAT) begin
        rdata_out <= {3'h0, evstat_r};
      end else if (addr_in == `ILWC_OFS_EVMASK) begin
        rdata_out <= {3'h0, evmask_r};
      end else if (is_shadow(addr_in)) begin
        rdata_out <= sh_rdata;
      end else if (addr_in == `ILWC_OFS_STATE) begin
        rdata_out <= {4'h0, lat_cnt_r, state_r};
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end
endmodule // ilwc_core

// ---- core/ilwc_regs.vh ----
// register offsets, field positions, reset values and timing counts of the interrupt unit
`ifndef ILWC_REGS_VH
`define ILWC_REGS_VH
// register port addresses (8-bit data)
`define ILWC_ADDR_W 4
`define ILWC_OFS_ICTRL 4'h0
`define ILWC_OFS_EDGE 4'h1
`define ILWC_OFS_EVSTAT 4'h2
`define ILWC_OFS_EVMASK 4'h3
`define ILWC_OFS_SH_W 4'h4
`define ILWC_OFS_SH_STATUS 4'h5
`define ILWC_OFS_SH_BANK 4'h6
`define ILWC_OFS_SH_FSR0L 4'h7
`define ILWC_OFS_SH_FSR0H 4'h8
`define ILWC_OFS_SH_FSR1L 4'h9
`define ILWC_OFS_SH_FSR1H 4'hA
`define ILWC_OFS_SH_PC_HIGH_LATCH 4'hB
`define ILWC_OFS_STATE 4'hC
// shadow bank in data memory
`define ILWC_SHADOW_BANK 5'h1F
`define ILWC_SHADOW_CNT 8
// interrupt control fields
`define ILWC_B_GIE 7
`define ILWC_B_PERIPHERAL_IRQ_ENABLE 6
`define ILWC_B_T0IE 5
`define ILWC_B_EXTE 4
`define ILWC_B_IOCE 3
`define ILWC_B_T0IF 2
`define ILWC_B_EXTF 1
`define ILWC_B_IOCF 0
`define ILWC_ICTRL_RST 8'h00
`define ILWC_ICTRL_WMASK 8'hFE
// status bits excluded from shadowing: timeout and powerdown
`define ILWC_STATUS_SAVE_MASK 8'hE7
// event status bits
`define ILWC_EV_ENTRY 0
`define ILWC_EV_EXIT 1
`define ILWC_EV_WAKE 2
`define ILWC_EV_EXT 3
`define ILWC_EV_EDGE 4
`define ILWC_EV_W 5
`define ILWC_EVMASK_RST 5'h00
// vector and latency, counted in instruction cycles
`define ILWC_VECTOR 15'h0004
`define ILWC_PC_W 15
`define ILWC_LAT_SYNC 3
`define ILWC_LAT_ASYNC_EXTRA 1
// latency counter reload: sync latency minus the cycle end that arms it
`define ILWC_LAT_LOAD 2'h2
`endif

// ---- core/ilwc_edge_det.v ----
// external pin edge detector with selectable polarity
`timescale 1ns/1ps
module ilwc_edge_det (
  input wire clock_in,
  input wire nrst_in,
  input wire pin_in,
  input wire rising_sel_in,
  output reg edge_out
);
  reg pin_q1_r;
  reg pin_q2_r;
  reg pin_prev_r;
  reg [1:0] warm_r;
  wire edge_nxt;

  // pin is asynchronous: two stages before use
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_q1_r <= 1'b0;
      pin_q2_r <= 1'b0;
      pin_prev_r <= 1'b0;
      edge_out <= 1'b0;
      warm_r <= 2'h0;
    end else begin
      if (warm_r != 2'h3) begin
        warm_r <= warm_r + 2'h1;
      end
      pin_q1_r <= pin_in;
      pin_q2_r <= pin_q1_r;
      pin_prev_r <= pin_q2_r;
      edge_out <= edge_nxt;
    end
  end

  // no edge until both stages hold real samples: a pin idling high must not look like a rising edge
  assign edge_nxt = (warm_r == 2'h3) &
                    (rising_sel_in ? (pin_q2_r & ~pin_prev_r) : (~pin_q2_r & pin_prev_r));
endmodule // ilwc_edge_det

// ---- core/ilwc_shadow.v ----
// shadow register array for automatic context saving
`timescale 1ns/1ps
`include "ilwc_regs.vh"
module ilwc_shadow (
  input wire clock_in,
  input wire nrst_in,
  input wire save_in,
  input wire [63:0] ctx_in,
  input wire sw_we_in,
  input wire [2:0] sw_idx_in,
  input wire [7:0] sw_data_in,
  input wire [2:0] rd_idx_in,
  output wire [7:0] rd_data_out,
  output wire [63:0] ctx_out
);
  reg [7:0] shadow_r [0:`ILWC_SHADOW_CNT-1];
  integer i;

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (i = 0; i < `ILWC_SHADOW_CNT; i = i + 1) begin
        shadow_r[i] <= 8'h00;
      end
    end else if (save_in) begin
      for (i = 0; i < `ILWC_SHADOW_CNT; i = i + 1) begin
        shadow_r[i] <= ctx_in[i*8 +: 8];
      end
    end else if (sw_we_in) begin
      shadow_r[sw_idx_in] <= sw_data_in;
    end
  end

  assign rd_data_out = shadow_r[rd_idx_in];
  genvar g;
  generate
    for (g = 0; g < `ILWC_SHADOW_CNT; g = g + 1) begin : g_out
      assign ctx_out[g*8 +: 8] = shadow_r[g];
    end
  endgenerate
endmodule // ilwc_shadow

// ---- tb/ilwc_core_props.sv ----
// assertion checker for the interrupt control unit ports
`timescale 1ns/1ps
`include "ilwc_regs.vh"
module ilwc_core_chk (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic cyc_end_in,
  input wire logic ret_isr_in,
  input wire logic sleeping_in,
  input wire logic wake_event_in,
  input wire logic flush_out,
  input wire logic push_out,
  input wire logic vector_load_out,
  input wire logic [`ILWC_PC_W-1:0] vector_out,
  input wire logic pop_out,
  input wire logic restore_out,
  input wire logic wake_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  sequence take_s;
    flush_out && push_out && vector_load_out;
  endsequence
  sequence leave_s;
    pop_out && restore_out;
  endsequence
  a_take_whole: assert property ((flush_out || push_out || vector_load_out) |-> take_s)
    else $error("take pulses split");
  a_leave_whole: assert property ((pop_out || restore_out) |-> leave_s)
    else $error("return pulses split");
  a_vector_fixed: assert property (vector_out == `ILWC_VECTOR)
    else $error("vector address wrong");
  // a take only ever follows the close of an instruction cycle
  a_take_at_end: assert property (take_s |-> $past(cyc_end_in))
    else $error("take not aligned to cycle end");
  a_take_gap: assert property (take_s |=> (!flush_out) [*3])
    else $error("take repeated too soon");
  a_leave_cause: assert property (leave_s |-> $past(ret_isr_in) || $past(ret_isr_in, 2))
    else $error("return without cause");
  a_no_clash: assert property (not (take_s and leave_s))
    else $error("take and return together");
  a_wake_copy: assert property (wake_out == ($past(sleeping_in) && $past(wake_event_in)))
    else $error("wake output wrong");
  a_read_quiet: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
endmodule // ilwc_core_chk
////////////////////////////////////////////////////////////////
bind ilwc_core ilwc_core_chk chk_u (.clock_in, .nrst_in, .rd_in, .rdata_out, .cyc_end_in, .ret_isr_in,
  .sleeping_in, .wake_event_in, .flush_out, .push_out, .vector_load_out, .vector_out, .pop_out,
  .restore_out, .wake_out);

// ---- tb/ilwc_seq_model.sv ----
// instruction-cycle phase source standing in for the core sequencer
`timescale 1ns/1ps
module ilwc_seq_model (
  input wire logic clock_in,
  input wire logic nrst_in,
  output logic cyc_end_out,
  output logic q4_out
);
  logic [1:0] phase_r;
  // four clocks per instruction cycle; runs in sleep too, so wake timing stays simple
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in)
      phase_r <= 2'h0;
    else
      phase_r <= phase_r + 2'h1;
  end
  assign cyc_end_out = (phase_r == 2'h3);
  assign q4_out = (phase_r == 2'h3) || (phase_r == 2'h0);
endmodule // ilwc_seq_model

// ---- tb/irq_latency_wake_context_unit_tb.sv ----
// self-checking bench for the interrupt control unit
`timescale 1ns/1ps
`include "ilwc_regs.vh"
module irq_latency_wake_context_unit_tb;
  logic clock_in, nrst_in, wr_in, rd_in, ext_pin_in, timer0_ovf_in, pin_change_in, periph_irq_in;
  logic sleeping_in, wake_event_in, ret_isr_in, bank31_we_in, cyc_end_in, q4_in;
  logic flush_out, push_out, vector_load_out, pop_out, restore_out, wake_out, irq_out;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, bank31_data_in, bank31_rdata_out;
  logic [2:0] bank31_idx_in;
  logic [14:0] pc_in, push_pc_out, vector_out;
  logic [63:0] ctx_in, restore_ctx_out;
  int error_cnt, total_checks, s;
  ilwc_core dut_u (.clock_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .cyc_end_in, .q4_in,
    .ext_pin_in, .timer0_ovf_in, .pin_change_in, .periph_irq_in, .sleeping_in, .wake_event_in, .ret_isr_in,
    .pc_in, .ctx_in, .bank31_we_in, .bank31_idx_in, .bank31_data_in, .bank31_rdata_out, .flush_out, .push_out,
    .push_pc_out, .vector_load_out, .vector_out, .pop_out, .restore_out, .restore_ctx_out, .wake_out, .irq_out);
  ilwc_seq_model seq_u (.clock_in, .nrst_in, .cyc_end_out(cyc_end_in), .q4_out(q4_in));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  task t0_pulse;
    @(posedge clock_in);
    timer0_ovf_in <= 1'b1;
    @(posedge clock_in);
    timer0_ovf_in <= 1'b0;
  endtask
  // counts cycle ends until a take; hi of 0 means no take may come
  task take(input int lo, input int hi);
    int n;
    bit seen;
    n = 0;
    seen = 0;
    repeat (80) if (!seen) begin
      #1;
      if (flush_out === 1'b1) begin
        seen = 1;
        chk({push_out, vector_load_out, vector_out, push_pc_out}, {2'b11, `ILWC_VECTOR, pc_in});
        chk(n >= lo && n <= hi, 1);
      end
      else if (cyc_end_in === 1'b1)
        n++;
      @(posedge clock_in);
    end
    chk(seen, hi != 0);
    if (!seen && hi != 0)
      give_verdict;
  endtask
  task leave(input logic [63:0] e);
    int i;
    @(posedge clock_in);
    ret_isr_in <= 1'b1;
    @(posedge clock_in);
    ret_isr_in <= 1'b0;
    #1;
    for (i = 0; i < 8 && pop_out !== 1'b1; i++) begin
      @(posedge clock_in);
      #1;
    end
    chk({pop_out, restore_out, restore_ctx_out}, {2'b11, e});
    if (pop_out !== 1'b1)
      give_verdict;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {nrst_in, wr_in, rd_in, ext_pin_in, timer0_ovf_in, pin_change_in, periph_irq_in, sleeping_in} = '0;
    {wake_event_in, ret_isr_in, bank31_we_in, addr_in, wdata_in, bank31_idx_in, bank31_data_in} = '0;
    pc_in = 15'h1234;
    ctx_in = 64'h887766554433FFC0;
    error_cnt = 0;
    total_checks = 0;
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(`ILWC_OFS_ICTRL, `ILWC_ICTRL_RST);
    rd(`ILWC_OFS_EVMASK, 8'h00);
    wr(`ILWC_OFS_ICTRL, 8'h7F);
    rd(`ILWC_OFS_ICTRL, 8'h7E);
    wr(`ILWC_OFS_ICTRL, 8'h00);
    t0_pulse;
    rd(`ILWC_OFS_ICTRL, 8'h04);
    // each polarity: idle, selected edge, then the other edge
    for (s = 0; s < 2; s++) begin
      wr(`ILWC_OFS_EDGE, {7'h00, s[0]});
      ext_pin_in <= ~s[0];
      wr(`ILWC_OFS_ICTRL, 8'h00);
      repeat (12) @(posedge clock_in);
      rd(`ILWC_OFS_ICTRL, 8'h00);
      ext_pin_in <= s[0];
      repeat (12) @(posedge clock_in);
      rd(`ILWC_OFS_ICTRL, 8'h02);
      ext_pin_in <= ~s[0];
      wr(`ILWC_OFS_ICTRL, 8'h00);
      repeat (12) @(posedge clock_in);
      rd(`ILWC_OFS_ICTRL, 8'h00);
    end
    wr(`ILWC_OFS_EVSTAT, 8'hFF);
    wr(`ILWC_OFS_EVMASK, 8'h01);
    wr(`ILWC_OFS_ICTRL, 8'hA0);
    t0_pulse;
    take(3, 4);
    ctx_in <= 64'h0;
    rd(`ILWC_OFS_ICTRL, 8'h24);
    rd(`ILWC_OFS_SH_STATUS, 8'hE7);
    wr(`ILWC_OFS_SH_W, 8'h5A);
    wr(`ILWC_OFS_ICTRL, 8'h20);
    chk(irq_out, 1);
    leave(64'h887766554433E75A);
    rd(`ILWC_OFS_ICTRL, 8'hA0);
    wr(`ILWC_OFS_EVMASK, 8'h00);
    rd(`ILWC_OFS_EVSTAT, 8'h03);
    chk(irq_out, 0);
    wr(`ILWC_OFS_EVSTAT, 8'h03);
    wr(`ILWC_OFS_EVMASK, 8'h03);
    rd(`ILWC_OFS_EVSTAT, 8'h00);
    chk(irq_out, 0);
    wr(`ILWC_OFS_ICTRL, 8'h80);
    periph_irq_in <= 1'b1;
    take(0, 0);
    wr(`ILWC_OFS_ICTRL, 8'hC0);
    take(3, 4);
    periph_irq_in <= 1'b0;
    leave(64'h0);
    wr(`ILWC_OFS_EDGE, 8'h01);
    wr(`ILWC_OFS_ICTRL, 8'h90);
    ext_pin_in <= 1'b1;
    take(3, 5);
    wr(`ILWC_OFS_ICTRL, 8'h10);
    leave(64'h0);
    wr(`ILWC_OFS_ICTRL, 8'h20);
    sleeping_in <= 1'b1;
    wake_event_in <= 1'b1;
    @(posedge clock_in);
    wake_event_in <= 1'b0;
    #1 chk(wake_out, 1);
    take(0, 0);
    // still asleep: a pending enabled request must wait for the wake and one instruction
    wr(`ILWC_OFS_ICTRL, 8'hA4);
    wake_event_in <= 1'b1;
    @(posedge clock_in);
    wake_event_in <= 1'b0;
    sleeping_in <= 1'b0;
    take(4, 4);
    wr(`ILWC_OFS_ICTRL, 8'h20);
    leave(64'h0);
    bank31_idx_in <= 3'h2;
    bank31_data_in <= 8'h3C;
    bank31_we_in <= 1'b1;
    @(posedge clock_in);
    bank31_we_in <= 1'b0;
    @(posedge clock_in);
    #1 chk(bank31_rdata_out, 8'h3C);
    rd(`ILWC_OFS_SH_BANK, 8'h3C);
    rd(`ILWC_OFS_STATE, 8'h08);
    rd(4'hD, 8'h00);
    give_verdict;
  end
endmodule // irq_latency_wake_context_unit_tb
